// ===== verilog/pcb_pkg.sv
// shared constants, types and functions for the command bank link
package pcb_pkg;
   // transfer kinds on the link
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ  = 2'h2;
   localparam logic [1:0] OP_SEND  = 2'h3;

   // widths of the link fields
   localparam int IDX_W     = 5;
   localparam int LEN_W     = 6;
   localparam int CAPTURE_W = 256;

   // read-only and send-byte command codes
   localparam logic [7:0] CODE_IDENT   = 8'he4;
   localparam logic [7:0] CODE_CAPTURE = 8'hea;
   localparam logic [7:0] CODE_MARKS   = 8'heb;
   localparam logic [7:0] CODE_FACTORY = 8'hf4;
   localparam logic [7:0] CODE_TIER    = 8'hfa;
   localparam logic [LEN_W-1:0] LEN_IDENT   = 6'h04;
   localparam logic [LEN_W-1:0] LEN_CAPTURE = 6'h20;
   localparam logic [LEN_W-1:0] LEN_MARKS   = 6'h02;
   localparam logic [LEN_W-1:0] LEN_TIER    = 6'h01;
   localparam logic [15:0]      MARKS_VALUE = 16'hffff;
   localparam logic [7:0]       TIER_PUBLIC = 8'h01;

   // store and restore codes that call for the long pause
   localparam logic [7:0] CODE_STORE_DEF = 8'h11;
   localparam logic [7:0] CODE_REST_DEF  = 8'h12;
   localparam logic [7:0] CODE_STORE_USR = 8'h15;
   localparam logic [7:0] CODE_REST_USR  = 8'h16;
   // codes meant to be written while the output is on
   localparam logic [7:0] CODE_OPERATION = 8'h01;
   localparam logic [7:0] CODE_ONOFF_CFG = 8'h02;
   localparam logic [7:0] CODE_CLR_FAULT = 8'h03;
   localparam logic [7:0] CODE_VOUT_CMD  = 8'h21;
   localparam logic [7:0] CODE_MGN_HIGH  = 8'h25;
   localparam logic [7:0] CODE_MGN_LOW   = 8'h26;

   // read/write settings, slot 20 first, slot 0 last
   localparam int NRW = 21;
   typedef logic [NRW-1:0][31:0] pcb_bank_t;
   localparam logic [NRW-1:0][7:0] RW_CODE = {
      8'hfd, 8'hfc, 8'hfb, 8'hf3, 8'hf0, 8'he9, 8'he8, 8'he7, 8'he6, 8'he5, 8'he2,
      8'he1, 8'he0, 8'hde, 8'hdd, 8'hdc, 8'hda, 8'hd9, 8'hd8, 8'hd7, 8'hd6};
   localparam logic [NRW-1:0][LEN_W-1:0] RW_LEN = {
      6'h02, 6'h02, 6'h02, 6'h01, 6'h01, 6'h02, 6'h02, 6'h02, 6'h01, 6'h01, 6'h04,
      6'h01, 6'h02, 6'h02, 6'h02, 6'h01, 6'h02, 6'h02, 6'h01, 6'h04, 6'h02};
   localparam pcb_bank_t RW_RESET = {
      32'h0000ffff, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
      32'h00002000, 32'h0000d5b7, 32'h0000d249, 32'h00000080, 32'h00000080,
      32'h00000000, 32'h00000000, 32'h00000000, 32'h00008686, 32'h00001014,
      32'h00000028, 32'h00008000, 32'h0000ba00, 32'h00000000, 32'h00000000,
      32'h0000ba00};

   // number formats
   localparam int EXP_LSB  = 11;
   localparam int FIX_EXP  = 13;

   // pacing of host commands
   localparam int CORE_HZ      = 25000000;
   localparam int READ_GAP_MS  = 2;
   localparam int OTHER_GAP_MS = 5;
   localparam int STORE_GAP_MS = 100;
   localparam int GAP_W        = 22;

   // finds the settings slot of a code
   function automatic logic [5:0] find_slot(input logic [7:0] code);
      logic [5:0] r;
      r = '0;
      for (int s = 0; s < NRW; s++) begin
         if (RW_CODE[s] == code) begin
            r = {1'b1, 5'(s)};
         end
      end
      return r;
   endfunction : find_slot

   // one byte out of a stored word
   function automatic logic [7:0] byte_at(input logic [31:0] w, input logic [1:0] i);
      return w[{i, 3'h0} +: 8];
   endfunction : byte_at

   // exponent field of the exponent-mantissa word
   function automatic logic signed [4:0] exp_mantissa_exp(input logic [15:0] w);
      return w[15:EXP_LSB];
   endfunction : exp_mantissa_exp

   // mantissa field of the exponent-mantissa word
   function automatic logic signed [10:0] exp_mantissa_mant(input logic [15:0] w);
      return w[EXP_LSB-1:0];
   endfunction : exp_mantissa_mant

   // integer part of the unsigned fixed-exponent format
   function automatic logic [2:0] fixed_exp_unsigned_int(input logic [15:0] w);
      return w[15:FIX_EXP];
   endfunction : fixed_exp_unsigned_int

   // integer part of the signed fixed-exponent format
   function automatic logic signed [2:0] fixed_exp_signed_int(input logic [15:0] w);
      return w[15:FIX_EXP];
   endfunction : fixed_exp_signed_int

   // store or restore commands that need the long pause
   function automatic logic is_store_restore(input logic [7:0] c);
      return c == CODE_STORE_DEF || c == CODE_REST_DEF || c == CODE_STORE_USR
          || c == CODE_REST_USR || c == CODE_FACTORY;
   endfunction : is_store_restore

   // codes that may be written while the output is enabled
   function automatic logic is_live_write(input logic [7:0] c, input logic [7:0] ft);
      return c == CODE_OPERATION || c == CODE_ONOFF_CFG || c == CODE_CLR_FAULT
          || c == CODE_VOUT_CMD || c == CODE_MGN_HIGH || c == CODE_MGN_LOW || c == ft;
   endfunction : is_live_write
endpackage : pcb_pkg

// ===== verilog/pcb_link_if.sv
// link between the host end and the command bank end
`timescale 1ns/10ps
`default_nettype none
interface pcb_link_if;
   logic       link_clk;
   logic       req;
   logic [1:0] op;
   logic [7:0] code;
   logic [4:0] idx;
   logic [7:0] wdata;
   logic       ack;
   logic [7:0] rdata;
   logic [5:0] len;
   logic       err;

   modport host_mp (output link_clk, req, op, code, idx, wdata,
                    input  ack, rdata, len, err);
   modport dev_mp  (input  link_clk, req, op, code, idx, wdata,
                    output ack, rdata, len, err);
endinterface : pcb_link_if
`default_nettype wire

// ===== verilog/pcb_dev_end.sv
// command bank end: settings, read-back and security registers on the link clock
//
// What this block and the host end do
// - exponent-mantissa word: 5-bit exponent, 11-bit mantissa
// - unsigned fixed-exponent word, value is mantissa/8192
// - signed fixed-exponent word, exponent minus 13
// - text commands move as variable-length byte blocks
// - reads answered at any time, output on too
// - host writes settings only while output disabled
// - written settings take effect at next enable
// - host pauses 100ms after store or restore
// - host leaves 2ms between reads
// - host leaves 5ms between other commands
// - store to user memory, power cycle, re-enable; this block answers the user store code with an error
// - inductance word resets to ba00h
// - output window fault byte resets to 00h
// - temperature gain/bias reset ba00h and 8000h
// - switch gap word resets to 1014h
// - over/undercurrent reaction bytes reset to 80h
// - average current limits reset d249h, d5b7h
// - capture command returns 32 read-only bytes
// - factory command reloads every default setting
// - access tier byte reads 1 after reset
// - passphrases default 0000h, guard mask ffffh
// - identity command returns read-only ascii string
`timescale 1ns/10ps
`default_nettype none
module pcb_dev_end #(
   parameter logic [31:0] IDENT_ASCII = 32'h31_42_43_50 // arbitrary identity text
) (
   pcb_link_if.dev_mp                         link,
   input  wire logic                          i_rstn,
   input  wire logic                          i_ce,
   input  wire logic                          i_out_enable,
   input  wire logic [pcb_pkg::CAPTURE_W-1:0] i_capture,
   output var  pcb_pkg::pcb_bank_t            o_active,
   output var  pcb_pkg::pcb_bank_t            o_stored,
   output logic                               o_comm_fault,
   output logic [7:0]                         o_tier
);
   import pcb_pkg::*;

   // one-hot answer states
   typedef enum logic [1:0] {
      D_IDLE = 2'b01,
      D_ACK  = 2'b10
   } pcb_dst_e;

   // whole state of this end
   typedef struct packed {
      pcb_dst_e          fsm;
      logic              req_m;
      logic              req_s;
      logic              en_m;
      logic              en_s;
      logic              en_d;
      logic              ack;
      logic [7:0]        rdata;
      logic [LEN_W-1:0]  len;
      logic              err;
      logic              comm_fault;
      logic [7:0]        tier;
      pcb_bank_t         pend;
      pcb_bank_t         act;
   } pcb_dev_s;

   // value after reset; the factory command reloads only its tier, both banks and the fault flag
   localparam pcb_dev_s DEV_RESET = '{
      fsm:   D_IDLE,
      tier:  TIER_PUBLIC,
      pend:  RW_RESET,
      act:   RW_RESET,
      default: '0
   };

   pcb_dev_s st_reg;
   pcb_dev_s st_next;

   // command decode of the fields held by the host
   logic [5:0]       slot_hit;
   logic [4:0]       slot;
   logic             hit;
   logic [LEN_W-1:0] rw_len;
   logic             in_range;

   assign slot_hit = find_slot(link.code);
   assign hit      = slot_hit[5];
   assign slot     = slot_hit[4:0];
   assign rw_len   = hit ? RW_LEN[slot] : '0;
   assign in_range = {1'b0, link.idx} < rw_len;

   // next state: synchronisers, pending apply and the request handshake
   always_comb begin
      st_next = st_reg;
      st_next.req_m = link.req;
      st_next.req_s = st_reg.req_m;
      st_next.en_m  = i_out_enable;
      st_next.en_s  = st_reg.en_m;
      st_next.en_d  = st_reg.en_s;

      // held settings go live on the rising edge of the output enable
      if (st_reg.en_s && !st_reg.en_d) begin
         st_next.act = st_reg.pend;
      end

      case (st_reg.fsm)
         D_IDLE: begin
            if (st_reg.req_s) begin
               st_next.fsm   = D_ACK;
               st_next.ack   = 1'b1;
               st_next.rdata = '0;
               st_next.err   = 1'b0;
               st_next.len   = rw_len;
               case (link.op)
                  // reads are served whatever the output state
                  OP_READ: begin
                     if (hit && in_range) begin
                        st_next.rdata = byte_at(st_reg.pend[slot], link.idx[1:0]);
                     end else if (link.code == CODE_IDENT) begin
                        st_next.len = LEN_IDENT;
                        st_next.err = {1'b0, link.idx} >= LEN_IDENT;
                        st_next.rdata = byte_at(IDENT_ASCII, link.idx[1:0]);
                     end else if (link.code == CODE_CAPTURE) begin
                        st_next.len   = LEN_CAPTURE;
                        st_next.rdata = i_capture[{link.idx, 3'h0} +: 8];
                     end else if (link.code == CODE_MARKS) begin
                        st_next.len   = LEN_MARKS;
                        st_next.err   = {1'b0, link.idx} >= LEN_MARKS;
                        st_next.rdata = byte_at({16'h0000, MARKS_VALUE}, link.idx[1:0]);
                     end else if (link.code == CODE_TIER) begin
                        st_next.len   = LEN_TIER;
                        st_next.err   = {1'b0, link.idx} >= LEN_TIER;
                        st_next.rdata = st_reg.tier;
                     end else begin
                        st_next.err = 1'b1;
                     end
                  end
                  // byte-wise writes into the held copy, text blocks alike
                  OP_WRITE: begin
                     if (hit && in_range) begin
                        st_next.pend[slot][{link.idx[1:0], 3'h0} +: 8] = link.wdata;
                     end else begin
                        st_next.err = 1'b1;
                     end
                  end
                  // only the factory reload is a data-less command here
                  OP_SEND: begin
                     if (link.code == CODE_FACTORY) begin
                        st_next.pend       = RW_RESET;
                        st_next.act        = RW_RESET;
                        st_next.tier       = TIER_PUBLIC;
                        st_next.comm_fault = 1'b0;
                        st_next.len        = '0;
                     end else begin
                        st_next.err = 1'b1;
                     end
                  end
                  default: begin
                     st_next.err = 1'b1;
                  end
               endcase
               // sticky fault follows every refused transfer
               if (st_next.err) begin
                  st_next.comm_fault = 1'b1;
               end
            end
         end
         // answer stands until the host drops its request
         D_ACK: begin
            if (!st_reg.req_s) begin
               st_next.fsm = D_IDLE;
               st_next.ack = 1'b0;
            end
         end
         default: begin
            st_next.fsm = D_IDLE;
            st_next.ack = 1'b0;
         end
      endcase
   end

   // state register on the link clock, reset loads the documented defaults
   always_ff @(posedge link.link_clk) begin
      if (!i_rstn) begin
         st_reg <= DEV_RESET;
      end else if (i_ce) begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register
   assign link.ack     = st_reg.ack;
   assign link.rdata   = st_reg.rdata;
   assign link.len     = st_reg.len;
   assign link.err     = st_reg.err;
   assign o_active     = st_reg.act;
   assign o_stored     = st_reg.pend;
   assign o_comm_fault = st_reg.comm_fault;
   assign o_tier       = st_reg.tier;

   // reset values of the table live in the package constant
   // slot 0 inductance, 2 window fault, 3 and 4 temperature
   // slot 6 switch gap, 11 and 12 reactions, 13 and 14 limits
   // slots 18 to 20 passphrases and guard mask
endmodule : pcb_dev_end
`default_nettype wire

// ===== verilog/pcb_host_end.sv
// host end: makes the link clock, runs the handshake and paces commands
`timescale 1ns/10ps
`default_nettype none
module pcb_host_end #(
   parameter int unsigned   READ_GAP_CYC  = pcb_pkg::READ_GAP_MS * (pcb_pkg::CORE_HZ / 1000),
   parameter int unsigned   OTHER_GAP_CYC = pcb_pkg::OTHER_GAP_MS * (pcb_pkg::CORE_HZ / 1000),
   parameter int unsigned   STORE_GAP_CYC = pcb_pkg::STORE_GAP_MS * (pcb_pkg::CORE_HZ / 1000),
   parameter logic [7:0]    FAST_XIENT_CODE = 8'h00
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_ce,
   input  wire logic        i_start,
   input  wire logic [1:0]  i_op,
   input  wire logic [7:0]  i_code,
   input  wire logic [4:0]  i_idx,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_dev_enabled,
   output logic             o_busy,
   output logic             o_done,
   output logic             o_refused,
   output logic [7:0]       o_rdata,
   output logic [5:0]       o_len,
   output logic             o_err,
   pcb_link_if.host_mp      link
);
   import pcb_pkg::*;

   // one-hot transfer states
   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_REQ  = 4'b0010,
      H_REL  = 4'b0100,
      H_GAP  = 4'b1000
   } pcb_hst_e;

   // whole state of this end
   typedef struct packed {
      pcb_hst_e         fsm;
      logic             div;
      logic             ack_m;
      logic             ack_s;
      logic             req;
      logic [1:0]       op;
      logic [7:0]       code;
      logic [4:0]       idx;
      logic [7:0]       wdata;
      logic             last;
      logic [GAP_W-1:0] gap;
      logic             busy;
      logic             done;
      logic             refused;
      logic [7:0]       rdata;
      logic [LEN_W-1:0] len;
      logic             err;
   } pcb_host_s;

   localparam pcb_host_s HOST_RESET = '{fsm: H_IDLE, default: '0};

   pcb_host_s st_reg;
   pcb_host_s st_next;

   // next state: clock divider, ack synchroniser and transfer sequence
   always_comb begin
      st_next = st_reg;
      st_next.div     = ~st_reg.div;
      st_next.ack_m   = link.ack;
      st_next.ack_s   = st_reg.ack_m;
      st_next.done    = 1'b0;
      st_next.refused = 1'b0;
      case (st_reg.fsm)
         H_IDLE: begin
            if (i_start) begin
               // settings writes are refused while the output is enabled
               if (i_op == OP_WRITE && i_dev_enabled
                   && !is_live_write(i_code, FAST_XIENT_CODE)) begin
                  st_next.refused = 1'b1;
               end else begin
                  st_next.fsm   = H_REQ;
                  st_next.req   = 1'b1;
                  st_next.op    = i_op;
                  st_next.code  = i_code;
                  st_next.idx   = i_idx;
                  st_next.wdata = i_wdata;
               end
            end
         end
         // wait for the answer, then pick the pause that follows it
         H_REQ: begin
            if (st_reg.ack_s) begin
               st_next.fsm   = H_REL;
               st_next.req   = 1'b0;
               st_next.done  = 1'b1;
               st_next.rdata = link.rdata;
               st_next.len   = link.len;
               st_next.err   = link.err;
               st_next.last  = link.err || st_reg.op == OP_SEND
                            || {1'b0, st_reg.idx} + 6'h01 >= link.len;
               if (is_store_restore(st_reg.code)) begin
                  st_next.gap = GAP_W'(STORE_GAP_CYC - 1);
               end else if (st_reg.op == OP_READ) begin
                  st_next.gap = GAP_W'(READ_GAP_CYC - 1);
               end else begin
                  st_next.gap = GAP_W'(OTHER_GAP_CYC - 1);
               end
            end
         end
         // pause only after the last byte of a command
         H_REL: begin
            if (!st_reg.ack_s) begin
               st_next.fsm = st_reg.last ? H_GAP : H_IDLE;
            end
         end
         H_GAP: begin
            if (st_reg.gap == '0) begin
               st_next.fsm = H_IDLE;
            end else begin
               st_next.gap = st_reg.gap - GAP_W'(1);
            end
         end
         default: begin
            st_next.fsm = H_IDLE;
            st_next.req = 1'b0;
         end
      endcase
      // start while busy is refused
      if (i_start && st_reg.fsm != H_IDLE) begin
         st_next.refused = 1'b1;
      end
      st_next.busy = st_next.fsm != H_IDLE;
   end

   // state register on the core clock
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         st_reg <= HOST_RESET;
      end else if (i_ce) begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register
   assign link.link_clk = st_reg.div;
   assign link.req      = st_reg.req;
   assign link.op       = st_reg.op;
   assign link.code     = st_reg.code;
   assign link.idx      = st_reg.idx;
   assign link.wdata    = st_reg.wdata;
   assign o_busy        = st_reg.busy;
   assign o_done        = st_reg.done;
   assign o_refused     = st_reg.refused;
   assign o_rdata       = st_reg.rdata;
   assign o_len         = st_reg.len;
   assign o_err         = st_reg.err;
endmodule : pcb_host_end
`default_nettype wire

// ===== test/pcb_link_assertions.sv
// concurrent checks on the link between the host end and the command bank end
`timescale 1ns/10ps
`default_nettype none
module pcb_link_assertions
   import pcb_pkg::*;
(
   input wire logic       link_clk,
   input wire logic       i_rstn,
   input wire logic       req,
   input wire logic [1:0] op,
   input wire logic [7:0] code,
   input wire logic [4:0] idx,
   input wire logic       ack,
   input wire logic [7:0] rdata,
   input wire logic [5:0] len,
   input wire logic       err
);
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (!i_rstn);

   // handshake steps and answer kinds
   sequence s_req_rise; $rose(req); endsequence
   sequence s_answer; ##[1:8] ack; endsequence
   sequence s_rd(logic [7:0] c); ack && op == OP_READ && code == c; endsequence
   sequence s_wr; ack && op == OP_WRITE; endsequence

   property p_answered; s_req_rise |-> s_answer; endproperty
   a_answered: assert property (p_answered) else $error("request not answered");
   property p_ack_hold; ack && req |=> ack; endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("answer dropped early");
   property p_release; $fell(req) |-> ##[1:5] !ack; endproperty
   a_release: assert property (p_release) else $error("answer not withdrawn");
   property p_tier; s_rd(CODE_TIER) ##0 idx == 5'h00 |-> rdata == 8'h01 && !err; endproperty
   a_tier: assert property (p_tier) else $error("tier read wrong");
   property p_capture; s_rd(8'hea) |-> len == 6'h20 && !err; endproperty
   a_capture: assert property (p_capture) else $error("capture length wrong");
   property p_ident; s_rd(8'he4) |-> len == 6'h04 && err == (idx > 5'h03); endproperty
   a_ident: assert property (p_ident) else $error("identity answer wrong");
   property p_ro_write; s_wr ##0 code inside {8'he4, 8'hea, 8'heb, 8'hfa} |-> err; endproperty
   a_ro_write: assert property (p_ro_write) else $error("read-only write accepted");
   property p_factory; ack && op == OP_SEND && code == 8'hf4 |-> !err && len == 6'h00;
   endproperty
   a_factory: assert property (p_factory) else $error("factory reload errored");
   property p_guard_len; s_rd(8'hfd) |-> len == 6'h02; endproperty
   a_guard_len: assert property (p_guard_len) else $error("guard mask length wrong");
   property p_byte_idx; s_wr ##0 code == 8'hd8 |-> err == (idx != 5'h00); endproperty
   a_byte_idx: assert property (p_byte_idx) else $error("byte setting index wrong");
endmodule : pcb_link_assertions
`default_nettype wire

// ===== test/pmbus_config_command_bank_tb_top.sv
// self-checking bench: host end and command bank end joined over the link
`timescale 1ns/10ps
`default_nettype none
module pmbus_config_command_bank_tb_top;
   import pcb_pkg::*;
   logic                 i_core_clk = 1'b0;
   logic                 host_rstn  = 1'b0;
   logic                 dev_rstn   = 1'b0;
   logic                 start      = 1'b0;
   logic [1:0]           op_s       = 2'h0;
   logic [7:0]           code_s     = 8'h00;
   logic [4:0]           idx_s      = 5'h00;
   logic [7:0]           wdata_s    = 8'h00;
   logic                 en         = 1'b0;
   logic                 ce         = 1'b1;
   logic [CAPTURE_W-1:0] capture;
   logic                 busy, done, refused, err, fault, got_ref, got_err;
   logic [7:0]           rdata, tier, got_d;
   logic [5:0]           len;
   pcb_bank_t            active, stored;
   int                   mismatches = 0;
   int                   n_tests = 0;
   int                   gap;
   logic [7:0]  rc [12] = '{8'hd6, 8'hd8, 8'hd9, 8'hda, 8'hdd, 8'he5, 8'he6, 8'he7, 8'he8,
                            8'hfb, 8'hfc, 8'hfd};
   logic [15:0] rv [12] = '{16'hba00, 16'h0000, 16'hba00, 16'h8000, 16'h1014, 16'h0080,
                            16'h0080, 16'hd249, 16'hd5b7, 16'h0000, 16'h0000, 16'hffff};

   pcb_link_if link ();
   pcb_host_end #(.READ_GAP_CYC(8), .OTHER_GAP_CYC(12), .STORE_GAP_CYC(20)) pcb_host_end_i (
      .i_core_clk(i_core_clk), .i_rstn(host_rstn), .i_ce(ce), .i_start(start), .i_op(op_s),
      .i_code(code_s), .i_idx(idx_s), .i_wdata(wdata_s), .i_dev_enabled(en), .o_busy(busy),
      .o_done(done), .o_refused(refused), .o_rdata(rdata), .o_len(len), .o_err(err),
      .link(link));
   pcb_dev_end #(.IDENT_ASCII(32'h44434241)) pcb_dev_end_i (
      .link(link), .i_rstn(dev_rstn), .i_ce(ce), .i_out_enable(en), .i_capture(capture),
      .o_active(active), .o_stored(stored), .o_comm_fault(fault), .o_tier(tier));
   pcb_link_assertions pcb_link_assertions_i (
      .link_clk(link.link_clk), .i_rstn(dev_rstn), .req(link.req), .op(link.op),
      .code(link.code), .idx(link.idx), .ack(link.ack), .rdata(link.rdata), .len(link.len),
      .err(link.err));

   // core clock, 40 ns period
   always #20 i_core_clk = ~i_core_clk;

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict

   // one byte transfer; optionally waits out the pause that follows it
   task automatic xfer(input logic [1:0] o, input logic [7:0] c, input logic [4:0] i,
                       input logic [7:0] d, input bit idle);
      int k;
      @(posedge i_core_clk);
      start <= 1'b1;
      op_s <= o;
      code_s <= c;
      idx_s <= i;
      wdata_s <= d;
      @(posedge i_core_clk);
      start <= 1'b0;
      k = 0;
      #1;
      while (!done && !refused && k < 400) begin
         @(posedge i_core_clk);
         #1;
         k++;
      end
      got_ref = refused;
      got_d = rdata;
      got_err = err;
      gap = 0;
      while (idle && busy && gap < 400) begin
         @(posedge i_core_clk);
         #1;
         gap++;
      end
      if (k == 400 || gap == 400) begin
         mismatches++;
         give_verdict();
      end
   endtask : xfer

   // main sequence
   initial begin
      for (int k = 0; k < 32; k++) begin
         capture[8*k +: 8] = 8'(k) ^ 8'h5a;
      end
      repeat (10) @(posedge i_core_clk);
      host_rstn <= 1'b1;
      repeat (10) @(posedge i_core_clk);
      dev_rstn <= 1'b1;
      for (int t = 0; t < 12; t++) begin
         for (int j = 0; j < 2; j++) begin
            xfer(OP_READ, rc[t], 5'(j), 8'h00, 1'b1);
            if (j == 0 || !(rc[t] inside {8'hd8, 8'he5, 8'he6})) begin
               check("reset byte", {24'h0, got_d}, {24'h0, rv[t][8*j +: 8]});
            end
         end
      end
      xfer(OP_READ, CODE_TIER, 5'h00, 8'h00, 1'b1);
      check("tier", {24'h0, got_d}, 32'h01);
      check("read pause", 32'(gap >= 8), 32'h1);
      xfer(OP_READ, 8'he4, 5'h00, 8'h00, 1'b1);
      check("ident", {24'h0, got_d}, 32'h41);
      xfer(OP_READ, 8'hea, 5'h1f, 8'h00, 1'b1);
      check("capture", {24'h0, got_d}, 32'h45);
      check("capture len", {26'h0, len}, 32'h20);
      xfer(OP_WRITE, CODE_TIER, 5'h00, 8'h07, 1'b1);
      check("ro write err", {31'h0, got_err}, 32'h1);
      check("comm fault", {31'h0, fault}, 32'h1);
      check("write pause", 32'(gap >= 12), 32'h1);
      xfer(OP_READ, CODE_TIER, 5'h00, 8'h00, 1'b1);
      check("tier kept", {24'h0, got_d}, 32'h01);
      xfer(OP_WRITE, 8'hd8, 5'h01, 8'h55, 1'b1);
      check("byte idx err", {31'h0, got_err}, 32'h1);
      check("byte kept", stored[2], 32'h00000000);
      xfer(OP_WRITE, 8'hd6, 5'h00, 8'h34, 1'b1);
      check("held", stored[0], 32'h0000ba34);
      check("not live", active[0], 32'h0000ba00);
      xfer(OP_READ, 8'hd8, 5'h00, 8'h00, 1'b0);
      xfer(OP_READ, 8'hd8, 5'h00, 8'h00, 1'b1);
      check("busy refusal", {31'h0, got_ref}, 32'h1);
      // enable edge while frozen must not apply the held settings yet
      @(posedge i_core_clk);
      ce <= 1'b0;
      en <= 1'b1;
      repeat (20) @(posedge i_core_clk);
      check("frozen", active[0], 32'h0000ba00);
      ce <= 1'b1;
      for (int k = 0; k < 50 && active[0] !== 32'h0000ba34; k++) begin
         @(posedge i_core_clk);
      end
      check("applied", active[0], 32'h0000ba34);
      xfer(OP_READ, 8'hd6, 5'h00, 8'h00, 1'b1);
      check("live read", {23'h0, got_ref, got_d}, 32'h34);
      xfer(OP_WRITE, 8'hd9, 5'h00, 8'h11, 1'b1);
      check("live refusal", {31'h0, got_ref}, 32'h1);
      check("unchanged", stored[3], 32'h0000ba00);
      xfer(OP_WRITE, CODE_VOUT_CMD, 5'h00, 8'h11, 1'b1);
      check("live exception", {31'h0, got_ref}, 32'h0);
      @(posedge i_core_clk);
      en <= 1'b0;
      xfer(OP_SEND, CODE_STORE_USR, 5'h00, 8'h00, 1'b1);
      check("user store pause", 32'(gap >= 20), 32'h1);
      xfer(OP_SEND, CODE_FACTORY, 5'h00, 8'h00, 1'b1);
      check("store pause", 32'(gap >= 20), 32'h1);
      check("factory stored", stored[0], 32'h0000ba00);
      check("factory active", active[0], 32'h0000ba00);
      check("fault cleared", {31'h0, fault}, 32'h0);
      // field split of the number formats on a known word
      check("exp field", {27'h0, exp_mantissa_exp(16'hba00)}, 32'h17);
      check("mantissa", {21'h0, exp_mantissa_mant(16'hba00)}, 32'h200);
      check("unsigned int", {29'h0, fixed_exp_unsigned_int(16'h2000)}, 32'h1);
      check("signed int", {29'h0, fixed_exp_signed_int(16'he000)}, 32'h7);
      give_verdict();
   end
endmodule : pmbus_config_command_bank_tb_top
`default_nettype wire
